// ---- hdl/ppoc_pkg.sv ----
// Constants and types for the port power and overcurrent sense controller
package ppoc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int NUM_PORTS = 7;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [15:0] OFF_START_LOCKOUT_TIME = 16'h30e1;
  localparam logic [15:0] OFF_SINGLE_PULSE_MIN_WIDTH = 16'h30ea;
  localparam logic [15:0] OFF_DOUBLE_PULSE_WINDOW = 16'h30eb;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout and reset values
  localparam int MIN_WIDTH_MSB = 3;
  localparam logic [7:0] RST_START_LOCKOUT_TIME = 8'h0a;
  localparam logic [7:0] RST_DOUBLE_PULSE_WINDOW = 8'h14;
  localparam logic [3:0] RST_SINGLE_PULSE_MIN_WIDTH = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one millisecond tick derived from the 20 MHz clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_US = 1000;
  localparam int MS_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [7:0] lockout;
    logic [7:0] window;
    logic [3:0] min_width;
  } ppoc_cfg_t;

  typedef enum logic [1:0] {
    st_off,
    st_lockout,
    st_active
  } ppoc_state_t;

endpackage : ppoc_pkg

// ---- hdl/ppoc_regs.sv ----
// Timer configuration registers of the port power controller
`timescale 1ns/100ps
module ppoc_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [15:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata_q,
  // Configuration to the port logic
  output ppoc_pkg::ppoc_cfg_t cfg_q
);

  ppoc_pkg::ppoc_cfg_t cfg_d;
  logic [7:0] rdata_d;

  always_comb begin
    cfg_d = cfg_q;
    rdata_d = cfg_rdata_q;
    if (cfg_wr) begin
      unique case (cfg_addr)
        ppoc_pkg::OFF_START_LOCKOUT_TIME: cfg_d.lockout = cfg_wdata; // R07
        ppoc_pkg::OFF_DOUBLE_PULSE_WINDOW: cfg_d.window = cfg_wdata; // R03
        ppoc_pkg::OFF_SINGLE_PULSE_MIN_WIDTH: begin
          cfg_d.min_width = cfg_wdata[ppoc_pkg::MIN_WIDTH_MSB:0]; // R02
        end
        default: ;
      endcase
    end
    if (cfg_rd) begin
      unique case (cfg_addr)
        ppoc_pkg::OFF_START_LOCKOUT_TIME: rdata_d = cfg_q.lockout;
        ppoc_pkg::OFF_DOUBLE_PULSE_WINDOW: rdata_d = cfg_q.window;
        // Upper nibble is reserved and reads zero
        ppoc_pkg::OFF_SINGLE_PULSE_MIN_WIDTH: rdata_d = {4'h0, cfg_q.min_width};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cfg_q.lockout <= ppoc_pkg::RST_START_LOCKOUT_TIME; // R07
      cfg_q.window <= ppoc_pkg::RST_DOUBLE_PULSE_WINDOW; // R04
      cfg_q.min_width <= ppoc_pkg::RST_SINGLE_PULSE_MIN_WIDTH;
      cfg_rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      cfg_rdata_q <= rdata_d;
    end
  end

  a_reset_defaults: assert property (@(posedge clock) !rst_b |=>
    cfg_q.lockout == 8'h0a && cfg_q.window == 8'h14) // R04
    else $error("timer registers not at reset defaults");

endmodule : ppoc_regs

// ---- hdl/ppoc_top.sv ----
// Per-port power control and overcurrent sense for the downstream ports
//
// What this block does
// R01: Single-pulse minimum width programmable zero to five ms in one ms steps.
// R02: The four-bit width field is a binary count of milliseconds.
// R03: Eight-bit window in ms within which two low pulses raise overcurrent.
// R04: Double-pulse window resets to twenty ms, value 8'h14.
// R05: Software never programs the window or lockout timer to zero.
// R06: After power on, sense lows are ignored until the lockout elapses.
// R07: Lockout counts in ms steps and resets to ten ms, value 8'h0a.
// R08: Power off drives the pin low and disables its pull-up.
// R09: Power on releases the driver and enables the pull-up, open drain.
// R10: A low on the sense input of a powered port means overcurrent.
// R11: Poly-fuse configurations set both power-good descriptor delays to zero; this block holds no descriptors and sets no delay.
// R12: USB 2.0 and USB 3 power of a split port operate independently.
// R13: Continuous low for the minimum width flags overcurrent.
// R14: Two separate low groups within the window flag overcurrent.
// R15: Lockout restarts on each power-on; power-off clears detection state.
`timescale 1ns/100ps
module ppoc_top #(
  parameter int unsigned MS_CYCLES = ppoc_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [15:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata_q,
  // Hub port power requests
  input wire logic [6:0] port_power_en,
  input wire logic [6:0] split_en,
  input wire logic [6:0] usb3_power_en,
  // Shared power control and sense pins
  input wire logic [6:0] port_power_sense_pin_i,
  output logic [6:0] port_power_sense_pin_o_q,
  output logic [6:0] port_power_sense_pin_oe_q,
  output logic [6:0] pullup_en_q,
  // Split USB 3 power and overcurrent events
  output logic [6:0] usb3_split_power_q,
  output logic [6:0] overcurrent_q
);

  ppoc_pkg::ppoc_cfg_t cfg_q;
  logic [15:0] tick_cnt_q;
  logic [15:0] tick_cnt_d;
  logic ms_tick_q;
  logic ms_tick_d;

  ////////////////////////////////////////////////////////////////////////////
  // Timer configuration
  ppoc_regs u_regs (
    .clock(clock),
    .rst_b(rst_b),
    .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata_q(cfg_rdata_q),
    .cfg_q(cfg_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared millisecond tick; all ports share it, so timings are quantised
  // to the tick and a measured time may fall short by up to one tick
  always_comb begin
    ms_tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 16'h0001;
    if (tick_cnt_q == 16'(MS_CYCLES - 1)) begin
      tick_cnt_d = 16'h0000;
      ms_tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tick_cnt_q <= 16'h0000;
      ms_tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      ms_tick_q <= ms_tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port state machines
  for (genvar i = 0; i < ppoc_pkg::NUM_PORTS; i++) begin : g_port
    ppoc_pkg::ppoc_state_t st_q;
    ppoc_pkg::ppoc_state_t st_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [3:0] low_ms_q;
    logic [3:0] low_ms_d;
    logic grp_q;
    logic grp_d;
    logic gap_q;
    logic gap_d;
    logic oc_d;
    logic oe_q;
    logic pu_q;
    logic u3_q;
    logic u3_d;
    logic oc_q;
    logic low;

    assign low = !port_power_sense_pin_i[i]; // R10

    always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      low_ms_d = low_ms_q;
      grp_d = grp_q;
      gap_d = gap_q;
      oc_d = 1'b0;
      unique case (st_q)
        ppoc_pkg::st_off: begin
          if (port_power_en[i]) begin
            st_d = ppoc_pkg::st_lockout; // R15
            cnt_d = cfg_q.lockout; // R07
          end
        end
        ppoc_pkg::st_lockout: begin
          // Sense level is not looked at here; slow pin ramps would trip it
          if (!port_power_en[i]) begin
            st_d = ppoc_pkg::st_off;
          end else if (ms_tick_q) begin
            // A zero lockout is treated as one tick rather than wrapping
            if (cnt_q <= 8'h01) begin
              st_d = ppoc_pkg::st_active; // R06
              cnt_d = 8'h00;
            end else begin
              cnt_d = cnt_q - 8'h01; // R07
            end
          end
        end
        ppoc_pkg::st_active: begin
          if (!port_power_en[i]) begin
            st_d = ppoc_pkg::st_off;
          end else begin
            if (grp_q && ms_tick_q) begin
              if (cnt_q <= 8'h01) begin
                grp_d = 1'b0; // R03
                gap_d = 1'b0;
                cnt_d = 8'h00;
              end else begin
                cnt_d = cnt_q - 8'h01;
              end
            end
            if (low) begin
              if (cfg_q.min_width == 4'h0 || low_ms_q >= cfg_q.min_width) begin
                oc_d = 1'b1; // R13
              end
              if (grp_q && gap_q) begin
                oc_d = 1'b1; // R14
              end
              if (!grp_q) begin
                grp_d = 1'b1; // R03
                cnt_d = cfg_q.window;
              end
              if (ms_tick_q && low_ms_q != 4'hf) begin
                low_ms_d = low_ms_q + 4'h1; // R01 R02
              end
            end else begin
              low_ms_d = 4'h0;
              if (grp_q) begin
                gap_d = 1'b1; // R14
              end
            end
            if (oc_d) begin
              grp_d = 1'b0;
              gap_d = 1'b0;
              low_ms_d = 4'h0;
              cnt_d = 8'h00;
            end
          end
        end
        // The fourth state code is unused; fall back to unpowered
        default: st_d = ppoc_pkg::st_off;
      endcase
      if (st_d == ppoc_pkg::st_off) begin
        grp_d = 1'b0; // R15
        gap_d = 1'b0;
        low_ms_d = 4'h0;
      end
      // Split ports take USB 3 power from their own request
      u3_d = split_en[i] ? usb3_power_en[i] : (st_d != ppoc_pkg::st_off); // R12
    end

    always_ff @(posedge clock) begin
      if (!rst_b) begin
        st_q <= ppoc_pkg::st_off;
        cnt_q <= 8'h00;
        low_ms_q <= 4'h0;
        grp_q <= 1'b0;
        gap_q <= 1'b0;
        oc_q <= 1'b0;
        oe_q <= 1'b1;
        pu_q <= 1'b0;
        u3_q <= 1'b0;
      end else begin
        st_q <= st_d;
        cnt_q <= cnt_d;
        low_ms_q <= low_ms_d;
        grp_q <= grp_d;
        gap_q <= gap_d;
        oc_q <= oc_d;
        oe_q <= (st_d == ppoc_pkg::st_off); // R08 R09
        pu_q <= (st_d != ppoc_pkg::st_off); // R08 R09
        u3_q <= u3_d;
      end
    end

    // Pin data is always low: the pin is either driven low or released
    assign port_power_sense_pin_o_q[i] = 1'b0;
    assign port_power_sense_pin_oe_q[i] = oe_q;
    assign pullup_en_q[i] = pu_q;
    assign usb3_split_power_q[i] = u3_q;
    assign overcurrent_q[i] = oc_q;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    a_off_drives_low: assert property (@(posedge clock) disable iff (!rst_b)
      !port_power_en[i] |=> oe_q && !pu_q) // R08
      else $error("unpowered port pin not driven low");

    a_on_releases: assert property (@(posedge clock) disable iff (!rst_b)
      port_power_en[i] && st_q == ppoc_pkg::st_off |=> !oe_q && pu_q) // R09
      else $error("powered port pin not released to pull-up");

    a_lockout_start: assert property (@(posedge clock) disable iff (!rst_b)
      port_power_en[i] && st_q == ppoc_pkg::st_off |=>
      st_q == ppoc_pkg::st_lockout && cnt_q == $past(cfg_q.lockout)) // R15
      else $error("lockout not restarted at power on");

    a_lockout_silent: assert property (@(posedge clock) disable iff (!rst_b)
      st_q == ppoc_pkg::st_lockout |=> !oc_q) // R06
      else $error("overcurrent raised during lockout");

    a_zero_width: assert property (@(posedge clock) disable iff (!rst_b)
      st_q == ppoc_pkg::st_active && port_power_en[i] && low &&
      cfg_q.min_width == 4'h0 |=> oc_q) // R01
      else $error("zero width low sample missed");

    a_single_width: assert property (@(posedge clock) disable iff (!rst_b)
      st_q == ppoc_pkg::st_active && port_power_en[i] && low &&
      low_ms_q >= cfg_q.min_width |=> oc_q) // R13
      else $error("continuous low pulse not flagged");

    a_double_pulse: assert property (@(posedge clock) disable iff (!rst_b)
      st_q == ppoc_pkg::st_active && port_power_en[i] && low && grp_q && gap_q
      |=> oc_q) // R14
      else $error("second low pulse in window not flagged");

    a_window_load: assert property (@(posedge clock) disable iff (!rst_b)
      st_q == ppoc_pkg::st_active && port_power_en[i] && low && !grp_q &&
      cfg_q.min_width != 4'h0 && low_ms_q < cfg_q.min_width
      |=> grp_q && cnt_q == $past(cfg_q.window)) // R03
      else $error("double pulse window not started");

    a_off_clears: assert property (@(posedge clock) disable iff (!rst_b)
      !port_power_en[i] |=> st_q == ppoc_pkg::st_off && !grp_q && !gap_q) // R15
      else $error("detection state kept while unpowered");

    a_split_power: assert property (@(posedge clock) disable iff (!rst_b)
      split_en[i] |=> u3_q == $past(usb3_power_en[i])) // R12
      else $error("split USB 3 power not following its request");
  end

endmodule : ppoc_top

// ---- tb/ppoc_switch_model.sv ----
// Power switch and pull-up network model on the shared port pins
`timescale 1ns/100ps
module ppoc_switch_model (
  // Clock
  input wire logic clock,
  // Hub side of the pins
  input wire logic [6:0] pin_o,
  input wire logic [6:0] pin_oe,
  input wire logic [6:0] pullup_en,
  // Commanded faults, high = switch pulls its flag low
  input wire logic [6:0] fault,
  // Resolved pin level
  output logic [6:0] pin
);
  logic [6:0] float_q = 7'h55;
  // A pin nobody drives or pulls must not settle to a friendly level
  always_ff @(posedge clock) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (pin_oe[i]) pin[i] = pin_o[i];
      else if (fault[i]) pin[i] = 1'b0;
      else if (pullup_en[i]) pin[i] = 1'b1;
      else pin[i] = float_q[i];
    end
  end
endmodule : ppoc_switch_model

// ---- tb/testbench.sv ----
// Self-checking bench for the port power and overcurrent controller
`timescale 1ns/100ps
module testbench;
  localparam int MS = 4;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [15:0] cfg_addr = 16'h0000;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata_q;
  logic [6:0] pwr = 7'h00;
  logic [6:0] split = 7'h00;
  logic [6:0] pwr3 = 7'h00;
  logic [6:0] fault = 7'h00;
  logic [6:0] pin, pin_o, pin_oe, pull, pwr3_q, oc;
  int num_errors = 0;
  int total_checks = 0;
  int n;

  initial forever #25 clock = ~clock;

  ppoc_top #(.MS_CYCLES(MS)) dut (.clock(clock), .rst_b(rst_b), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata_q(cfg_rdata_q), .port_power_en(pwr), .split_en(split),
    .usb3_power_en(pwr3), .port_power_sense_pin_i(pin),
    .port_power_sense_pin_o_q(pin_o), .port_power_sense_pin_oe_q(pin_oe),
    .pullup_en_q(pull), .usb3_split_power_q(pwr3_q), .overcurrent_q(oc));
  ppoc_switch_model sw (.clock(clock), .pin_o(pin_o), .pin_oe(pin_oe),
    .pullup_en(pull), .fault(fault), .pin(pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chk_in(input int lo, input int hi);
    chk({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask : chk_in

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_rd <= 1'b0;
    @(negedge clock);
    chk(cfg_rdata_q, exp);
  endtask : rd

  task automatic power(input logic on);
    @(posedge clock);
    pwr[0] <= on;
    fault[0] <= 1'b0;
  endtask : power

  // One low sample, then gap high cycles
  task automatic pulse(input int gap);
    @(posedge clock);
    fault[0] <= 1'b1;
    @(posedge clock);
    fault[0] <= 1'b0;
    repeat (gap) @(posedge clock);
  endtask : pulse

  // Leaves in n the negedges waited before the one that saw the event, max if no event came
  task automatic wait_oc(input int max);
    for (n = 0; n < max; n++) begin
      @(negedge clock);
      if (oc[0] === 1'b1) break;
    end
  endtask : wait_oc

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(50 * 4000);
    num_errors++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk({7'h00, pin_oe[0]}, 8'h01);
    chk({7'h00, pull[0]}, 8'h00);
    chk({1'b0, pin_o}, 8'h00);
    rd(16'h30e1, 8'h0a);
    rd(16'h30eb, 8'h14);
    rd(16'h30ea, 8'h01);
    rd(16'h30e0, 8'h00);
    wr(16'h30ea, 8'hf3);
    rd(16'h30ea, 8'h03);
    wr(16'h30eb, 8'h08);
    rd(16'h30eb, 8'h08);
    $display("registers done");
    wr(16'h30e1, 8'h03);
    wr(16'h30ea, 8'h00);
    power(1'b1);
    // Fault is raised one edge later so that power() and this line never
    // assign it in the same time step
    @(posedge clock);
    fault[0] <= 1'b1;
    @(negedge clock);
    chk({7'h00, pin_oe[0]}, 8'h00);
    chk({7'h00, pull[0]}, 8'h01);
    wait_oc(6 * MS);
    chk_in(2 * MS - 2, 4 * MS + 2);
    power(1'b0);
    $display("lockout done");
    wr(16'h30e1, 8'h01);
    for (int w = 0; w < 6; w++) begin
      wr(16'h30ea, 8'(w));
      power(1'b1);
      repeat (3 * MS) @(posedge clock);
      fault[0] <= 1'b1;
      wait_oc(7 * MS);
      chk_in(w == 0 ? 0 : w * MS - MS, w * MS + 3);
      power(1'b0);
    end
    $display("single width done");
    wr(16'h30ea, 8'h05);
    power(1'b1);
    repeat (3 * MS) @(posedge clock);
    pulse(2);
    pulse(0);
    wait_oc(4);
    chk_in(0, 3);
    @(negedge clock);
    chk({7'h00, oc[0]}, 8'h00);
    wr(16'h30eb, 8'h02);
    pulse(4 * MS);
    pulse(0);
    wait_oc(2 * MS);
    chk_in(2 * MS, 2 * MS);
    wr(16'h30eb, 8'h08);
    pulse(2);
    power(1'b0);
    power(1'b1);
    repeat (3 * MS) @(posedge clock);
    pulse(0);
    wait_oc(2 * MS);
    chk_in(2 * MS, 2 * MS);
    $display("double pulse done");
    @(posedge clock);
    split <= 7'h60;
    pwr3 <= 7'h40;
    pwr <= 7'h21;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk({1'b0, pwr3_q}, 8'h41);
    chk({1'b0, pull}, 8'h21);
    chk({1'b0, oc}, 8'h00);
    $display("split done");
    conclude();
  end
endmodule : testbench
